// ### design/eldl_pkg.sv
// Package of constants and types for the dimming level control block.
package eldl_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int STARTUP_TIME_US = 1000;
  localparam int STARTUP_CYCLES = (CLK_HZ / 1000000) * STARTUP_TIME_US;

  // ---------------------------------------------------------------
  // Level codes and amplitudes
  // ---------------------------------------------------------------
  localparam int LEVEL_W = 3;
  localparam logic [LEVEL_W-1:0] LEVEL_DEFAULT = 3'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_OFF = 3'h7;
  localparam logic [LEVEL_W-1:0] LEVEL_STEP = 3'h1;
  localparam int AMP_W = 7;
  localparam logic [AMP_W-1:0] AMP_OFF = 7'h00;

  typedef enum logic [2:0] {
    ELDL_STANDBY = 3'b001,
    ELDL_STARTUP = 3'b010,
    ELDL_ACTIVE  = 3'b100
  } eldl_state_t;

  // Drive amplitude in volts for a level code.
  function automatic logic [AMP_W-1:0] eldl_amplitude(input logic [LEVEL_W-1:0] code);
    case (code)
      3'h0: eldl_amplitude = 7'h55;
      3'h1: eldl_amplitude = 7'h4E;
      3'h2: eldl_amplitude = 7'h47;
      3'h3: eldl_amplitude = 7'h40;
      3'h4: eldl_amplitude = 7'h39;
      3'h5: eldl_amplitude = 7'h32;
      3'h6: eldl_amplitude = 7'h2B;
      default: eldl_amplitude = AMP_OFF;
    endcase
  endfunction

endpackage

// ### design/eldl_sync.sv
// Two-flop synchroniser for one pin input.
`timescale 1ns/1ps
module eldl_sync (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = pin_in;
    next_sync = meta;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule // eldl_sync

// ### design/eldl_level_ctrl.sv
// Dimming level controller: enable, startup timer, pulse counter, amplitude select.
//
// How it works
// - Device runs while enable is high and is fully off while it is low.
// - Amplitude is one of seven fixed levels, plus an off state.
// - On enable the level code starts at zero, giving 85 volts.
// - A 3-bit counter counts dimming pulses, codes zero through seven.
// - Each falling dimming edge after startup advances the code by one and changes amplitude; edges during startup are ignored.
// - Codes one to six give 78, 71, 64, 57, 50, 43 volts.
// - Code seven switches the panel drive off with zero amplitude.
// - The counter wraps modulo eight, the eighth pulse restores 85 volts.
// - Undriven enable and dimming inputs read low through pull-downs.
`timescale 1ns/1ps
module eldl_level_ctrl #(
  parameter int STARTUP_CNT = eldl_pkg::STARTUP_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic dimming_pulse_in,
  output logic [eldl_pkg::LEVEL_W-1:0] level_code_out,
  output logic [eldl_pkg::AMP_W-1:0] amplitude_out,
  output logic drive_on_out,
  output logic panel_drive_out_a,
  output logic panel_drive_out_b,
  output logic ready_out
);
  import eldl_pkg::*;

  localparam int TMR_W = $clog2(STARTUP_CNT + 1);

  // A startup count below one leaves the timer compare without a reachable end point.
  if (STARTUP_CNT < 1) begin : g_bad_startup_cnt
    $error("STARTUP_CNT must be at least one");
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // The pads carry pull-downs; reset values of the synchronisers read low.
  logic enable_sync;
  logic dim_sync;

  eldl_sync u_sync_enable (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .pin_in(enable_in),
    .sync_out(enable_sync)
  );

  eldl_sync u_sync_dim (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .pin_in(dimming_pulse_in),
    .sync_out(dim_sync)
  );

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  eldl_state_t state;
  eldl_state_t next_state;
  logic [TMR_W-1:0] timer;
  logic [TMR_W-1:0] next_timer;
  logic dim_prev;
  logic next_dim_prev;
  logic [LEVEL_W-1:0] level;
  logic [LEVEL_W-1:0] next_level;
  logic dim_fall;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_level = level;
    next_dim_prev = dim_sync;
    dim_fall = dim_prev && !dim_sync;
    case (state)
      ELDL_STANDBY: begin
        next_timer = '0;
        next_level = LEVEL_DEFAULT;
        if (enable_sync) begin
          next_state = ELDL_STARTUP;
        end
      end
      ELDL_STARTUP: begin
        next_level = LEVEL_DEFAULT;
        if (!enable_sync) begin
          next_state = ELDL_STANDBY;
          next_timer = '0;
        end else if (timer == TMR_W'(STARTUP_CNT - 1)) begin
          next_state = ELDL_ACTIVE;
        end else begin
          next_timer = timer + TMR_W'(1);
        end
      end
      ELDL_ACTIVE: begin
        if (!enable_sync) begin
          next_state = ELDL_STANDBY;
          next_timer = '0;
          next_level = LEVEL_DEFAULT;
        end else if (dim_fall) begin
          next_level = level + LEVEL_STEP;
        end
      end
      default: begin
        next_state = ELDL_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ELDL_STANDBY;
      timer <= '0;
      level <= LEVEL_DEFAULT;
      dim_prev <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      level <= next_level;
      dim_prev <= next_dim_prev;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic [AMP_W-1:0] next_amplitude;
  logic next_drive_on;
  logic next_ready;

  always_comb begin
    next_ready = (next_state == ELDL_ACTIVE);
    next_drive_on = (next_state != ELDL_STANDBY) && (next_level != LEVEL_OFF);
    next_amplitude = next_drive_on ? eldl_amplitude(next_level) : AMP_OFF;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_code_out <= LEVEL_DEFAULT;
      amplitude_out <= AMP_OFF;
      drive_on_out <= 1'b0;
      panel_drive_out_a <= 1'b0;
      panel_drive_out_b <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      level_code_out <= next_level;
      amplitude_out <= next_amplitude;
      drive_on_out <= next_drive_on;
      panel_drive_out_a <= next_drive_on;
      panel_drive_out_b <= next_drive_on;
      ready_out <= next_ready;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_off_when_disabled: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!enable_sync) |=> (!drive_on_out && amplitude_out == AMP_OFF))
    else $error("drive active while disabled");

  a_level_clear_standby: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == ELDL_STANDBY) |=> (level_code_out == LEVEL_DEFAULT && timer == '0))
    else $error("level or timer not cleared in standby");

  a_start_max_amp: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == ELDL_STANDBY && enable_sync) |=> (amplitude_out == 7'h55 && level_code_out == LEVEL_DEFAULT))
    else $error("startup amplitude not maximum");

  a_fall_advance: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == ELDL_ACTIVE && enable_sync && dim_fall) |=> (level == $past(level) + LEVEL_STEP))
    else $error("level did not advance on falling edge");

  a_hold_no_edge: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == ELDL_ACTIVE && enable_sync && !dim_fall) |=> $stable(level))
    else $error("level changed without an edge");

  a_code_seven_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (level_code_out == LEVEL_OFF) |-> (!drive_on_out && amplitude_out == AMP_OFF))
    else $error("drive on at code seven");

  a_amp_table: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (drive_on_out && level_code_out == 3'h6) |-> (amplitude_out == 7'h2B))
    else $error("wrong amplitude for code six");

  a_wrap_default: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == ELDL_ACTIVE && enable_sync && dim_fall && level == LEVEL_OFF) |=> (amplitude_out == 7'h55))
    else $error("wrap did not restore maximum");

  a_startup_ignore: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == ELDL_STARTUP) |-> (level == LEVEL_DEFAULT && level_code_out == LEVEL_DEFAULT && !ready_out))
    else $error("edge taken during startup");

  a_ready_time: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(ready_out) |-> ($past(timer) == TMR_W'(STARTUP_CNT - 1)))
    else $error("ready raised at wrong time");

  a_seven_level: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    drive_on_out |-> (amplitude_out != AMP_OFF && level_code_out != LEVEL_OFF))
    else $error("drive on without a level");

endmodule // eldl_level_ctrl

// ### dv/eldl_host_model.sv
// Host model that drives the enable and dimming pins of the level controller.
`timescale 1ns/1ps
module eldl_host_model (
  input wire logic clk_sys_in,
  input wire logic ready_in,
  output logic enable_out,
  output logic dimming_out
);
  import eldl_pkg::*;

  // Each pin level lasts 4 us: above the 3 us minimum, a burst rate near 125 kHz.
  localparam int PULSE_HALF_CYCLES = (CLK_HZ / 1000000) * 4;

  initial begin
    enable_out = 1'b0;
    dimming_out = 1'b0;
  end

  task automatic set_enable(input logic lvl);
    @(negedge clk_sys_in);
    enable_out = lvl;
  endtask

  // One dimming pulse; an early pulse does not wait for the startup interval to end.
  task automatic pulse(input bit early);
    int i;
    if (!early) begin
      for (i = 0; i < 200 && ready_in !== 1'b1; i++) @(negedge clk_sys_in);
    end
    @(negedge clk_sys_in);
    dimming_out = 1'b1;
    repeat (PULSE_HALF_CYCLES) @(negedge clk_sys_in);
    dimming_out = 1'b0;
    repeat (PULSE_HALF_CYCLES) @(negedge clk_sys_in);
  endtask

  task automatic burst(input int n);
    int i;
    for (i = 0; i < n; i++) pulse(1'b0);
  endtask
endmodule // eldl_host_model

// ### dv/el_dimming_level_control_test.sv
// Self-checking testbench of the dimming level controller.
`timescale 1ns/1ps
module el_dimming_level_control_test;
  import eldl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic enable;
  logic dimming;
  logic [LEVEL_W-1:0] level_code;
  logic [AMP_W-1:0] amplitude;
  logic drive_on, drive_a, drive_b, ready;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  localparam logic [AMP_W-1:0] AMP_TAB [8] = '{7'h55, 7'h4E, 7'h47, 7'h40, 7'h39, 7'h32, 7'h2B, 7'h00};

  always #20 clk_sys_in = ~clk_sys_in;

  eldl_host_model host (.clk_sys_in(clk_sys_in), .ready_in(ready), .enable_out(enable), .dimming_out(dimming));

  eldl_level_ctrl #(.STARTUP_CNT(400)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .enable_in(enable), .dimming_pulse_in(dimming),
    .level_code_out(level_code), .amplitude_out(amplitude), .drive_on_out(drive_on),
    .panel_drive_out_a(drive_a), .panel_drive_out_b(drive_b), .ready_out(ready)
  );

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_state(input logic [2:0] code, input logic on, input logic rdy);
    logic [AMP_W-1:0] exp_amp;
    exp_amp = on ? AMP_TAB[code] : AMP_OFF;
    check("level", 8'(level_code), 8'(code));
    check("amplitude", 8'(amplitude), 8'(exp_amp));
    check("drive", 8'(drive_on), 8'(on));
    check("drive_a", 8'(drive_a), 8'(on));
    check("drive_b", 8'(drive_b), 8'(on));
    check("ready", 8'(ready), 8'(rdy));
  endtask

  task automatic t_reset();
    check_state(3'h0, 1'b0, 1'b0);
    @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    check_state(3'h0, 1'b0, 1'b0);
    $display("reset test done");
  endtask

  task automatic t_enable();
    int i;
    host.set_enable(1'b1);
    repeat (4) @(negedge clk_sys_in);
    check_state(3'h0, 1'b1, 1'b0);
    host.pulse(1'b1);
    check_state(3'h0, 1'b1, 1'b0);
    for (i = 0; i < 1000 && ready !== 1'b1; i++) @(negedge clk_sys_in);
    check_state(3'h0, 1'b1, 1'b1);
    $display("enable test done");
  endtask

  task automatic t_walk();
    int i;
    logic [2:0] code;
    for (i = 1; i <= 8; i++) begin
      host.pulse(1'b0);
      code = 3'(i % 8);
      check_state(code, code != 3'h7, 1'b1);
    end
    $display("walk test done");
  endtask

  task automatic t_fade();
    host.burst(7);
    check_state(3'h7, 1'b0, 1'b1);
    repeat (50) @(negedge clk_sys_in);
    host.burst(7);
    check_state(3'h6, 1'b1, 1'b1);
    $display("fade test done");
  endtask

  task automatic t_disable();
    host.set_enable(1'b0);
    repeat (4) @(negedge clk_sys_in);
    check_state(3'h0, 1'b0, 1'b0);
    host.pulse(1'b1);
    check_state(3'h0, 1'b0, 1'b0);
    host.set_enable(1'b1);
    repeat (4) @(negedge clk_sys_in);
    check_state(3'h0, 1'b1, 1'b0);
    $display("disable test done");
  endtask

  initial begin
    repeat (10) @(negedge clk_sys_in);
    t_reset();
    t_enable();
    t_walk();
    t_fade();
    t_disable();
    final_report();
  end
endmodule // el_dimming_level_control_test
